// ==== rtl/vpiu_top.sv ====
`timescale 1ns/1ps
`include "vpiu_cfg.svh"
module vpiu_top import vpiu_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`VPIU_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`VPIU_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_pin_a_n,
  input wire logic ext_irq_pin_b_n,
  input wire logic [3:0] tmr_set,
  input wire logic [1:0] uart_set,
  input wire logic [5:0] ca_set,
  input wire logic [7:0] kbd_set,
  input wire logic [6:0] periph_set,
  input wire logic instr_last,
  input wire logic instr_blocked,
  input wire logic reti_done,
  output logic call_req,
  output logic [15:0] call_vector,
  output logic [1:0] call_level,
  output logic irq_out
);

  // ****************************************
  // state
  // ****************************************
  vpiu_byte_t en0_r, en1_r, plo0_r, plo1_r, phi0_r, phi1_r, emode_r;
  logic [`VPIU_IST_W-1:0] ist_r, ien_r, ist_nxt;
  logic [3:0][7:0] flg_r, flg_nxt, hwset_w, hwclr_w;
  logic [`VPIU_NSLOT-1:0] pend_r;
  logic [3:0] act_r, act_nxt;
  logic [2:0] call_cnt_r;
  logic wr_blk_r, call_req_r, irq_r;
  logic [15:0] call_vector_r;
  vpiu_lvl_t call_level_r;
  vpiu_slot_t call_slot_r;
  logic aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [`VPIU_AW-1:0] waddr_r;
  vpiu_byte_t wbyte_r;
  logic wlane_r;
  vpiu_resp_t bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ****************************************
  // register writes
  // ****************************************
  wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_lane = do_wr & wlane_r;
  wire wr_en0 = wr_lane & (waddr_r == `VPIU_OFS_EN0);
  wire wr_en1 = wr_lane & (waddr_r == `VPIU_OFS_EN1);
  wire wr_plo0 = wr_lane & (waddr_r == `VPIU_OFS_PLO0);
  wire wr_plo1 = wr_lane & (waddr_r == `VPIU_OFS_PLO1);
  wire wr_phi0 = wr_lane & (waddr_r == `VPIU_OFS_PHI0);
  wire wr_phi1 = wr_lane & (waddr_r == `VPIU_OFS_PHI1);
  wire wr_f0 = wr_lane & (waddr_r == `VPIU_OFS_FLG0);
  wire wr_f1 = wr_lane & (waddr_r == `VPIU_OFS_FLG1);
  wire wr_f2 = wr_lane & (waddr_r == `VPIU_OFS_FLG2);
  wire wr_f3 = wr_lane & (waddr_r == `VPIU_OFS_FLG3);
  wire wr_em = wr_lane & (waddr_r == `VPIU_OFS_EMODE);
  wire wr_iclr = wr_lane & (waddr_r == `VPIU_OFS_ICLR);
  wire wr_ien = wr_lane & (waddr_r == `VPIU_OFS_IEN);
  wire wr_prio = wr_en0 | wr_en1 | wr_plo0 | wr_plo1 | wr_phi0 | wr_phi1;
  wire wr_hit = (waddr_r[1:0] == 2'b00) & (waddr_r <= `VPIU_OFS_IEN);
  wire [3:0] flg_wr = {wr_f3, wr_f2, wr_f1, wr_f0};

  // ****************************************
  // external pins
  // ****************************************
  logic [1:0] pin_s, pin_d_r;
  vpiu_sync2 u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({ext_irq_pin_b_n, ext_irq_pin_a_n}),
    .sync_out(pin_s)
  );
  wire edge_a = emode_r[`VPIU_EM_EDGE_A];
  wire edge_b = emode_r[`VPIU_EM_EDGE_B];
  wire [1:0] pin_fall = pin_d_r & ~pin_s;
  // level mode: the flag follows the pin, the source owns it
  wire ext_a_set = edge_a ? pin_fall[0] : ~pin_s[0];
  wire ext_b_set = edge_b ? pin_fall[1] : ~pin_s[1];

  // ****************************************
  // request flags
  // ****************************************
  logic call_fire;
  vpiu_slot_t win_slot_w;
  wire vec_ea = call_fire & (win_slot_w == `VPIU_SLOT_EXT_A);
  wire vec_ta = call_fire & (win_slot_w == `VPIU_SLOT_TMR_A);
  wire vec_eb = call_fire & (win_slot_w == `VPIU_SLOT_EXT_B);
  wire vec_tb = call_fire & (win_slot_w == `VPIU_SLOT_TMR_B);
  wire clr_ea = (~edge_a & pin_s[0]) | (edge_a & vec_ea);
  wire clr_eb = (~edge_b & pin_s[1]) | (edge_b & vec_eb);

  assign hwset_w[0] = {tmr_set[3:2], uart_set, tmr_set[1], ext_b_set, tmr_set[0], ext_a_set};
  assign hwset_w[1] = {2'b00, ca_set};
  assign hwset_w[2] = kbd_set;
  assign hwset_w[3] = {1'b0, periph_set};
  assign hwclr_w[0] = {4'h0, vec_tb, clr_eb, vec_ta, clr_ea};
  assign hwclr_w[1] = 8'h00;
  assign hwclr_w[2] = 8'h00;
  assign hwclr_w[3] = 8'h00;

  localparam logic [3:0][7:0] FLG_MASK = {`VPIU_F3_MASK, 8'hff, `VPIU_F1_MASK, 8'hff};

  // a software write replaces the flag as hardware would; a hardware set in
  // the same cycle still wins so no event is lost
  for (genvar g = 0; g < 4; g++) begin : g_flag
    assign flg_nxt[g] = ((flg_wr[g] ? wbyte_r : (flg_r[g] & ~hwclr_w[g]))
                         | hwset_w[g]) & FLG_MASK[g];
  end

  wire [`VPIU_NSLOT-1:0] req_w = {
    flg_r[3][`VPIU_F3_ADC],
    |flg_r[3][`VPIU_F3_CMP],
    1'b0,
    |flg_r[3][`VPIU_F3_SPI],
    flg_r[3][`VPIU_F3_TW],
    |flg_r[2],
    |flg_r[1][`VPIU_F1_CA],
    |flg_r[0][`VPIU_F0_TMR_C],
    |flg_r[0][`VPIU_F0_UART],
    flg_r[0][`VPIU_F0_TMR_B],
    flg_r[0][`VPIU_F0_EXT_B],
    flg_r[0][`VPIU_F0_TMR_A],
    flg_r[0][`VPIU_F0_EXT_A]
  };
  wire [`VPIU_NSLOT-1:0] slot_en_w = `VPIU_SLOT_VEC(en0_r, en1_r);
  wire [`VPIU_NSLOT-1:0] slot_lo_w = `VPIU_SLOT_VEC(plo0_r, plo1_r);
  wire [`VPIU_NSLOT-1:0] slot_hi_w = `VPIU_SLOT_VEC(phi0_r, phi1_r);
  wire glb_en = en0_r[`VPIU_EN0_GLOBAL];
  wire [`VPIU_NSLOT-1:0] pend_w = req_w & slot_en_w & {`VPIU_NSLOT{glb_en}};

  // ****************************************
  // arbitration and vectoring
  // ****************************************
  logic win_vld_w;
  vpiu_lvl_t win_lvl_w;
  vpiu_prio_sel u_sel (
    .req(pend_r),
    .lvl_lo(slot_lo_w),
    .lvl_hi(slot_hi_w),
    .win_vld(win_vld_w),
    .win_slot(win_slot_w),
    .win_lvl(win_lvl_w)
  );

  wire busy_w = |act_r;
  wire vpiu_lvl_t cur_lvl_w = act_r[3] ? 2'd3 : act_r[2] ? 2'd2 : act_r[1] ? 2'd1 : 2'd0;
  // level 3 running can never be beaten, nothing compares higher
  wire lvl_ok_w = ~busy_w | (win_lvl_w > cur_lvl_w);
  wire blk_w = instr_blocked | wr_blk_r;
  wire poll_w = instr_last & (call_cnt_r == 3'd0);
  assign call_fire = poll_w & win_vld_w & lvl_ok_w & ~blk_w;
  wire held_w = poll_w & win_vld_w & ~call_fire;
  wire [15:0] vec_w = `VPIU_VEC_FIRST + {9'h000, win_slot_w, 3'b000};
  wire [3:0] reti_clr = (reti_done & busy_w) ? (4'h1 << cur_lvl_w) : 4'h0;
  wire [3:0] act_set = call_fire ? (4'h1 << win_lvl_w) : 4'h0;
  assign act_nxt = (act_r & ~reti_clr) | act_set;
  wire [`VPIU_IST_W-1:0] ist_ev = {held_w, call_fire};
  wire [`VPIU_IST_W-1:0] ist_clr = wr_iclr ? wbyte_r[`VPIU_IST_W-1:0] : 2'b00;
  assign ist_nxt = (ist_r & ~ist_clr) | ist_ev;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flg_r <= '0;
      pend_r <= '0;
      act_r <= 4'h0;
      pin_d_r <= 2'h3;
      ist_r <= '0;
      irq_r <= 1'b0;
    end else begin
      flg_r <= flg_nxt;
      pend_r <= pend_w;
      act_r <= act_nxt;
      pin_d_r <= pin_s;
      ist_r <= ist_nxt;
      irq_r <= |(ist_r & ien_r);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      call_req_r <= 1'b0;
      call_vector_r <= `VPIU_VEC_RESET;
      call_level_r <= 2'b00;
      call_slot_r <= `VPIU_SLOT_EXT_A;
      call_cnt_r <= 3'd0;
      wr_blk_r <= 1'b0;
    end else begin
      call_req_r <= call_fire;
      if (call_fire) begin
        call_vector_r <= vec_w;
        call_level_r <= win_lvl_w;
        call_slot_r <= win_slot_w;
      end
      // hold off the next poll while the core runs the call
      if (call_fire) begin
        call_cnt_r <= `VPIU_CALL_CYC;
      end else if (call_cnt_r != 3'd0) begin
        call_cnt_r <= call_cnt_r - 3'd1;
      end
      wr_blk_r <= wr_prio | (wr_blk_r & ~poll_w);
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en0_r <= `VPIU_RST_BYTE;
      en1_r <= `VPIU_RST_BYTE;
      plo0_r <= `VPIU_RST_BYTE;
      plo1_r <= `VPIU_RST_BYTE;
      phi0_r <= `VPIU_RST_BYTE;
      phi1_r <= `VPIU_RST_BYTE;
      emode_r <= `VPIU_RST_BYTE;
      ien_r <= '0;
    end else begin
      if (wr_en0) en0_r <= wbyte_r;
      if (wr_en1) en1_r <= wbyte_r;
      if (wr_plo0) plo0_r <= wbyte_r;
      if (wr_plo1) plo1_r <= wbyte_r;
      if (wr_phi0) phi0_r <= wbyte_r;
      if (wr_phi1) phi1_r <= wbyte_r;
      if (wr_em) emode_r <= wbyte_r;
      if (wr_ien) ien_r <= wbyte_r[`VPIU_IST_W-1:0];
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  wire [7:0] state_w = {call_level_r, win_vld_w, wr_blk_r, act_r};
  wire [7:0] rd_b =
    (s_axi_araddr == `VPIU_OFS_EN0) ? en0_r :
    (s_axi_araddr == `VPIU_OFS_EN1) ? en1_r :
    (s_axi_araddr == `VPIU_OFS_PLO0) ? plo0_r :
    (s_axi_araddr == `VPIU_OFS_PLO1) ? plo1_r :
    (s_axi_araddr == `VPIU_OFS_PHI0) ? phi0_r :
    (s_axi_araddr == `VPIU_OFS_PHI1) ? phi1_r :
    (s_axi_araddr == `VPIU_OFS_FLG0) ? flg_r[0] :
    (s_axi_araddr == `VPIU_OFS_FLG1) ? flg_r[1] :
    (s_axi_araddr == `VPIU_OFS_FLG2) ? flg_r[2] :
    (s_axi_araddr == `VPIU_OFS_FLG3) ? flg_r[3] :
    (s_axi_araddr == `VPIU_OFS_EMODE) ? emode_r :
    (s_axi_araddr == `VPIU_OFS_STATE) ? state_w :
    (s_axi_araddr == `VPIU_OFS_IST) ? {6'h00, ist_r} :
    (s_axi_araddr == `VPIU_OFS_IEN) ? {6'h00, ien_r} : 8'h00;
  wire rd_hit = (s_axi_araddr[1:0] == 2'b00) & (s_axi_araddr <= `VPIU_OFS_IEN);

  // address and data may arrive in either order; the answer waits for both
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= VPIU_RESP_OKAY;
      waddr_r <= '0;
      wbyte_r <= `VPIU_RST_BYTE;
      wlane_r <= 1'b0;
    end else begin
      if (s_axi_awvalid & awready_r) begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        waddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_r) begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? VPIU_RESP_OKAY : VPIU_RESP_SLVERR;
      end
      if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= VPIU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, rd_b};
        rresp_r <= rd_hit ? VPIU_RESP_OKAY : VPIU_RESP_SLVERR;
      end
      if (rvalid_r & s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign call_req = call_req_r;
  assign call_vector = call_vector_r;
  assign call_level = call_level_r;
  assign irq_out = irq_r;

  // ****************************************
  // checks
  // ****************************************
  vec_layout_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r |-> (call_vector_r[2:0] == 3'b011) && (call_vector_r != `VPIU_VEC_RESET))
    else $error("vector address off the vector grid");

  rsvd_vec_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r |-> call_vector_r != `VPIU_VEC_RSVD)
    else $error("reserved vector was called");

  glb_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r |-> $past(glb_en, 2))
    else $error("call issued while global enable was clear");

  src_enable_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r |-> ((($past(slot_en_w, 2) >> call_slot_r) & 13'h0001) != 13'h0000))
    else $error("call issued for a disabled source");

  preempt_lvl_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r |-> (!$past(busy_w) || (call_level_r > $past(cur_lvl_w))))
    else $error("service preempted by equal or lower level");

  top_lvl_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(act_r[3]) && !$past(reti_done) |-> !call_req_r)
    else $error("highest level service was interrupted");

  withhold_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r |-> !$past(instr_blocked) && !$past(wr_blk_r) && $past(instr_last))
    else $error("vectoring not withheld or not at instruction end");

  call_gap_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r |=> (!call_req_r) [*4])
    else $error("next call issued inside the call cycles");

  ca_order_a: assert property (@(posedge core_clk) disable iff (rst)
    win_vld_w && pend_r[`VPIU_SLOT_CA] && pend_r[`VPIU_SLOT_UART]
    && (slot_lo_w[`VPIU_SLOT_CA] == slot_lo_w[`VPIU_SLOT_UART])
    && (slot_hi_w[`VPIU_SLOT_CA] == slot_hi_w[`VPIU_SLOT_UART])
    |-> win_slot_w != `VPIU_SLOT_UART)
    else $error("serial port beat counter array at equal level");

  tmr_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    call_req_r && (call_slot_r == `VPIU_SLOT_TMR_A) && !$past(tmr_set[0]) && !$past(wr_f0)
    |-> !flg_r[0][`VPIU_F0_TMR_A])
    else $error("timer flag not cleared on vectoring");

  sw_set_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_f0 && wbyte_r[`VPIU_F0_TMR_B] |=> flg_r[0][`VPIU_F0_TMR_B])
    else $error("software flag set had no effect");

endmodule

// ==== rtl/vpiu_cfg.svh ====
// Functional notes
// - twelve vectors plus reset vector at base
// - shared vectors OR their source flags
// - each source has its own enable bit; here sources sharing a vector share one bit
// - global enable cleared blocks every request
// - software flag writes act like hardware
// - four levels from paired priority bits
// - only strictly higher level preempts service
// - highest level service is never interrupted
// - higher pending level is served first
// - equal levels: earlier poll position wins
// - counter array polled fifth, before serial
// - polling order only breaks level ties
// - 0053H reserved, converter last at 0063H
// - poll at last cycle, previous-cycle flags
// - no vectoring after return or enable writes
// - call takes four cycles before next poll
// - vectoring clears edge external, timer A and B flags
`ifndef VPIU_CFG_SVH
`define VPIU_CFG_SVH

// ****************************************
// register map, byte addresses
// ****************************************
`define VPIU_AW 8
`define VPIU_OFS_EN0 8'h00
`define VPIU_OFS_EN1 8'h04
`define VPIU_OFS_PLO0 8'h08
`define VPIU_OFS_PLO1 8'h0c
`define VPIU_OFS_PHI0 8'h10
`define VPIU_OFS_PHI1 8'h14
`define VPIU_OFS_FLG0 8'h18
`define VPIU_OFS_FLG1 8'h1c
`define VPIU_OFS_FLG2 8'h20
`define VPIU_OFS_FLG3 8'h24
`define VPIU_OFS_EMODE 8'h28
`define VPIU_OFS_STATE 8'h2c
`define VPIU_OFS_IST 8'h30
`define VPIU_OFS_ICLR 8'h34
`define VPIU_OFS_IEN 8'h38
`define VPIU_RST_BYTE 8'h00

// ****************************************
// field layouts
// ****************************************
`define VPIU_EN0_GLOBAL 7
`define VPIU_EM_EDGE_A 0
`define VPIU_EM_EDGE_B 1
`define VPIU_F1_MASK 8'h3f
`define VPIU_F3_MASK 8'h7f
`define VPIU_F0_EXT_A 0
`define VPIU_F0_TMR_A 1
`define VPIU_F0_EXT_B 2
`define VPIU_F0_TMR_B 3
`define VPIU_F0_UART 5:4
`define VPIU_F0_TMR_C 7:6
`define VPIU_F1_CA 5:0
`define VPIU_F3_TW 0
`define VPIU_F3_SPI 3:1
`define VPIU_F3_CMP 5:4
`define VPIU_F3_ADC 6
`define VPIU_IST_W 2
`define VPIU_IST_CALL 0
`define VPIU_IST_HELD 1
// per-slot vector from the two register halves, reserved slot forced low
`define VPIU_SLOT_VEC(a, b) {b[4:3], 1'b0, b[2:0], a[6:0]}

// ****************************************
// vectors and polling
// ****************************************
`define VPIU_NSLOT 13
`define VPIU_SLOT_EXT_A 4'h0
`define VPIU_SLOT_TMR_A 4'h1
`define VPIU_SLOT_EXT_B 4'h2
`define VPIU_SLOT_TMR_B 4'h3
`define VPIU_SLOT_UART 4'h4
`define VPIU_SLOT_CA 4'h6
`define VPIU_SLOT_RSVD 4'ha
`define VPIU_VEC_RESET 16'h0000
`define VPIU_VEC_FIRST 16'h0003
`define VPIU_VEC_RSVD 16'h0053
`define VPIU_POLL_MAP {4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h5, 4'h4, 4'h6, 4'h3, 4'h2, 4'h1, 4'h0}
`define VPIU_CALL_CYC 3'd4

`endif

// ==== rtl/vpiu_pkg.sv ====
package vpiu_pkg;
  typedef logic [1:0] vpiu_lvl_t;
  typedef logic [3:0] vpiu_slot_t;
  typedef logic [7:0] vpiu_byte_t;
  typedef enum logic [1:0] {
    VPIU_RESP_OKAY = 2'b00,
    VPIU_RESP_SLVERR = 2'b10
  } vpiu_resp_t;
endpackage

// ==== rtl/vpiu_sync2.sv ====
`timescale 1ns/1ps
module vpiu_sync2 import vpiu_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] meta_r;

  // pins idle high, so reset to the idle level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 2'h3;
      sync_out <= 2'h3;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ==== rtl/vpiu_prio_sel.sv ====
`timescale 1ns/1ps
`include "vpiu_cfg.svh"
module vpiu_prio_sel import vpiu_pkg::*; (
  input wire logic [`VPIU_NSLOT-1:0] req,
  input wire logic [`VPIU_NSLOT-1:0] lvl_lo,
  input wire logic [`VPIU_NSLOT-1:0] lvl_hi,
  output logic win_vld,
  output vpiu_slot_t win_slot,
  output vpiu_lvl_t win_lvl
);
  localparam logic [4*`VPIU_NSLOT-1:0] POLL_MAP = `VPIU_POLL_MAP;
  logic [`VPIU_NSLOT:0] c_vld;
  vpiu_slot_t c_slot [`VPIU_NSLOT+1];
  vpiu_lvl_t c_lvl [`VPIU_NSLOT+1];

  assign c_vld[0] = 1'b0;
  assign c_slot[0] = `VPIU_SLOT_EXT_A;
  assign c_lvl[0] = 2'b00;

  // walk the slots in polling order; a later one wins only on a higher level,
  // so ties stay with the earlier poll position
  for (genvar i = 0; i < `VPIU_NSLOT; i++) begin : g_poll
    wire vpiu_slot_t s = POLL_MAP[i*4 +: 4];
    wire vpiu_lvl_t l = {lvl_hi[s], lvl_lo[s]};
    wire take = req[s] & (~c_vld[i] | (l > c_lvl[i]));
    assign c_vld[i+1] = c_vld[i] | req[s];
    assign c_slot[i+1] = take ? s : c_slot[i];
    assign c_lvl[i+1] = take ? l : c_lvl[i];
  end

  assign win_vld = c_vld[`VPIU_NSLOT];
  assign win_slot = c_slot[`VPIU_NSLOT];
  assign win_lvl = c_lvl[`VPIU_NSLOT];
endmodule

// ==== test/vpiu_core_model.sv ====
`timescale 1ns/1ps
// ****************************************
// core model: two-cycle instructions
// ****************************************
module vpiu_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic call_req,
  input wire logic reti_cmd,
  output logic instr_last,
  output logic instr_blocked,
  output logic reti_done
);
  logic ph_r;
  logic [2:0] stall_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_r <= 1'b0;
      stall_r <= 3'h0;
    end else begin
      ph_r <= ~ph_r;
      // hardware call occupies four cycles, no poll meanwhile
      if (call_req) stall_r <= 3'h4;
      else if (stall_r != 3'h0) stall_r <= stall_r - 3'h1;
    end
  end
  // last cycle of each instruction is the poll cycle
  assign instr_last = ph_r && stall_r == 3'h0 && !call_req;
  // a return is its own poll cycle, so it must hold the vector back
  assign reti_done = instr_last && reti_cmd;
  assign instr_blocked = reti_done;
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "vpiu_cfg.svh"
module tb import vpiu_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic reti_cmd = 1'b0, ext_a_n = 1'b1, ext_b_n = 1'b1;
  logic [3:0] tmr_set = 4'h0;
  logic [1:0] uart_set = 2'h0;
  logic [5:0] ca_set = 6'h00;
  logic [7:0] kbd_set = 8'h00;
  logic [6:0] periph_set = 7'h00;
  logic awready, wready, bvalid, arready, rvalid, instr_last, instr_blocked, reti_done;
  logic call_req, irq_out;
  logic [1:0] bresp, rresp, call_level;
  logic [31:0] rdata;
  logic [15:0] call_vector;
  int n_fail = 0;
  int cmp_count = 0;
  always #25 core_clk = ~core_clk;
  vpiu_top dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_irq_pin_a_n(ext_a_n), .ext_irq_pin_b_n(ext_b_n), .tmr_set(tmr_set),
    .uart_set(uart_set), .ca_set(ca_set), .kbd_set(kbd_set), .periph_set(periph_set),
    .instr_last(instr_last), .instr_blocked(instr_blocked), .reti_done(reti_done),
    .call_req(call_req), .call_vector(call_vector), .call_level(call_level), .irq_out(irq_out));
  vpiu_core_model core (.core_clk(core_clk), .rst(rst), .call_req(call_req),
    .reti_cmd(reti_cmd), .instr_last(instr_last), .instr_blocked(instr_blocked),
    .reti_done(reti_done));
  // ****************************************
  // bench tasks
  // ****************************************
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic to;
    n_fail++;
    end_sim;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
      end
    end
    if (!done) to();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int i;
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
      end
    end
    if (!done) to();
  endtask
  task automatic pulse(input logic [3:0] t, input logic [1:0] u, input logic [5:0] c);
    @(posedge core_clk);
    tmr_set <= t;
    uart_set <= u;
    ca_set <= c;
    @(posedge core_clk);
    tmr_set <= 4'h0;
    uart_set <= 2'h0;
    ca_set <= 6'h00;
  endtask
  task automatic wait_call(input logic [15:0] vec, input logic [1:0] lvl);
    int i;
    for (i = 0; i < 60 && call_req !== 1'b1; i++) @(posedge core_clk);
    if (call_req !== 1'b1) to();
    chk(32'(call_vector), 32'(vec));
    chk(32'(call_level), 32'(lvl));
    @(posedge core_clk);
  endtask
  task automatic quiet(input int n);
    int i, seen;
    seen = 0;
    for (i = 0; i < n; i++) begin
      @(posedge core_clk);
      seen += (call_req === 1'b1);
    end
    chk(32'(seen), 32'h0000_0000);
  endtask
  task automatic reti;
    int i;
    @(posedge core_clk);
    reti_cmd <= 1'b1;
    for (i = 0; i < 20 && reti_done !== 1'b1; i++) @(posedge core_clk);
    reti_cmd <= 1'b0;
    if (reti_done !== 1'b1) to();
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0000_0000, 2'h0);
    rd(8'h3c, 32'h0000_0000, 2'h2);
    wr(8'h3c, 8'h01, 2'h2);
    $display("test registers done");
    wr(8'h38, 8'h01, 2'h0);
    wr(8'h00, 8'h0a, 2'h0);
    pulse(4'h3, 2'h0, 6'h00);
    quiet(30);
    wr(8'h00, 8'h8a, 2'h0);
    wait_call(16'h000b, 2'h0);
    rd(8'h18, 32'h0000_0008, 2'h0);
    wr(8'h10, 8'h08, 2'h0);
    wait_call(16'h001b, 2'h2);
    rd(8'h18, 32'h0000_0000, 2'h0);
    reti();
    reti();
    wr(8'h10, 8'h00, 2'h0);
    $display("test levels done");
    wr(8'h00, 8'hd0, 2'h0);
    pulse(4'h0, 2'h1, 6'h01);
    wait_call(16'h0033, 2'h0);
    wr(8'h1c, 8'h00, 2'h0);
    reti();
    wait_call(16'h0023, 2'h0);
    wr(8'h18, 8'h00, 2'h0);
    reti();
    $display("test polling done");
    wr(8'h04, 8'h10, 2'h0);
    wr(8'h00, 8'h80, 2'h0);
    wr(8'h24, 8'h40, 2'h0);
    wait_call(16'h0063, 2'h0);
    wr(8'h24, 8'h00, 2'h0);
    reti();
    chk(32'(irq_out), 32'h0000_0001);
    wr(8'h34, 8'h01, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(32'(irq_out), 32'h0000_0000);
    $display("test software flags done");
    wr(8'h28, 8'h01, 2'h0);
    wr(8'h08, 8'h03, 2'h0);
    wr(8'h10, 8'h03, 2'h0);
    wr(8'h00, 8'h83, 2'h0);
    ext_a_n <= 1'b0;
    wait_call(16'h0003, 2'h3);
    rd(8'h18, 32'h0000_0000, 2'h0);
    pulse(4'h1, 2'h0, 6'h00);
    quiet(20);
    reti();
    wait_call(16'h000b, 2'h3);
    ext_a_n <= 1'b1;
    reti();
    $display("test top level done");
    end_sim;
  end
endmodule
